// file: hw/ufl_format_ctrl.v
// fifo control and character format control of one serial channel, axi4-lite slave
//
// Summary of operation
// RL1 - reset clears the whole fifo control value; fifos off, lowest triggers.
// RL2 - fifo control bit 0 enables both fifos; clearing it empties both.
// RL3 - any switch between fifo mode and byte mode empties both fifos.
// RL4 - other fifo control bits are taken only when bit 0 is one.
// RL5 - bit 1 flushes receive fifo and zeroes its count, not shift register.
// RL6 - bit 2 flushes transmit fifo and zeroes its count, not shift register.
// RL7 - bit 3 picks transfer-request mode when enabled; no request pins exist.
// RL8 - deep build: bits 5:4 give transmit trigger 8, 16, 32 or 56.
// RL9 - bits 7:6 give receive trigger 1,4,8,14 or 8,16,56,60 when deep.
// RL10 - line control bits 1:0 choose five to eight data bits.
// RL11 - bit 2 clear gives one stop bit; set gives 1.5 for five bits, two otherwise.
// RL12 - bit 3 adds parity after data, checked on receive; bit 4 picks even.
// RL13 - stick parity sends and expects parity opposite the even select bit.
// RL14 - break forces serial output low; transmitter keeps running beneath it.
// RL15 - host loads zero byte, sets break, clears it after transmitter empty.
// RL16 - bit 7 steers low addresses to divisor latch bytes instead of buffers.
// RL17 - deep build: writing BF to line control opens the enhanced registers.
// RL18 - reset clears the whole line control value.
// RL19 - fifo control is write only; reads never return its value; status reads return its bits 3 and 0.
// RL20 - identification bits 7:6 read ones when fifos enabled, else zeros.
// RL21 - fifo depth parameter, 16 or 64, picks tables and deep-only features.
// RL22 - flush in the enabling write acts before any new character is stored.
`timescale 1ns/1ps
`include "ufl_map.vh"

module ufl_format_ctrl #(
  parameter FIFO_DEPTH = 64
) (
  // clock and reset
  input wire clk_sys_in,
  input wire rst_n_in,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output wire s_axi_awready_out,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output wire s_axi_wready_out,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp_out,
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output wire s_axi_arready_out,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in,
  // fifo occupancy from the data path
  input wire rx_push_in,
  input wire rx_pop_in,
  input wire tx_push_in,
  input wire tx_pop_in,
  // transmitter raw serial output from its shift register
  input wire tx_shift_in,
  // controls toward the data path
  output reg fifo_enable_out,
  output reg rx_fifo_flush_out,
  output reg tx_fifo_flush_out,
  output reg dma_mode_out,
  output reg [6:0] rx_trigger_out,
  output reg [6:0] tx_trigger_out,
  output reg [3:0] data_bits_out,
  output reg two_stop_out,
  output reg half_stop_out,
  output reg parity_enable_out,
  output reg parity_even_out,
  output reg parity_stick_out,
  output reg parity_stick_value_out,
  output reg divisor_access_out,
  output reg enhanced_access_out,
  output wire serial_out,
  // occupancy and trigger status
  output reg rx_trigger_hit_out,
  output reg tx_below_trigger_out
);

  // ==========================================================================
  // reset synchroniser
  reg rst_meta_ff;
  reg rst_sync_ff;
  wire rst_n;
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;

  localparam DEEP = (FIFO_DEPTH == `UFL_DEEP); // [RL21]

  // ==========================================================================
  // write channel: address and data taken in either order
  reg aw_held_ff;
  reg w_held_ff;
  reg [7:0] aw_addr_ff;
  reg [31:0] w_data_ff;
  reg [3:0] w_strb_ff;
  wire aw_take;
  wire w_take;
  wire wr_fire;
  assign s_axi_awready_out = !aw_held_ff && !s_axi_bvalid_out;
  assign s_axi_wready_out = !w_held_ff && !s_axi_bvalid_out;
  assign aw_take = s_axi_awvalid_in && s_axi_awready_out;
  assign w_take = s_axi_wvalid_in && s_axi_wready_out;
  assign wr_fire = aw_held_ff && w_held_ff;

  // capture address and data
  always @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else begin
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
      end else begin
        if (aw_take) begin
          aw_held_ff <= 1'b1;
          aw_addr_ff <= s_axi_awaddr_in;
        end
        if (w_take) begin
          w_held_ff <= 1'b1;
          w_data_ff <= s_axi_wdata_in;
          w_strb_ff <= s_axi_wstrb_in;
        end
      end
    end
  end

  // ==========================================================================
  // register decode of a write
  wire wr_lane0;
  wire wr_fc;
  wire wr_lc;
  wire wr_known;
  assign wr_lane0 = wr_fire && w_strb_ff[0];
  assign wr_fc = wr_lane0 && (aw_addr_ff[7:2] == `UFL_OFS_FIFO_CTRL >> 2);
  assign wr_lc = wr_lane0 && (aw_addr_ff[7:2] == `UFL_OFS_LINE_CTRL >> 2);
  assign wr_known = (aw_addr_ff[7:2] == `UFL_OFS_FIFO_CTRL >> 2) ||
                    (aw_addr_ff[7:2] == `UFL_OFS_LINE_CTRL >> 2);

  // write response
  always @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `UFL_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= wr_known ? `UFL_RESP_OKAY : `UFL_RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // ==========================================================================
  // fifo control register
  reg [7:0] fifo_ctrl_ff;
  reg [7:0] nxt_fifo_ctrl;
  wire [7:0] wbyte;
  assign wbyte = w_data_ff[7:0];
  always @* begin
    nxt_fifo_ctrl = fifo_ctrl_ff;
    if (wr_fc) begin
      nxt_fifo_ctrl[`UFL_FC_EN] = wbyte[`UFL_FC_EN]; // [RL2]
      if (wbyte[`UFL_FC_EN]) begin
        nxt_fifo_ctrl[7:1] = wbyte[7:1]; // [RL4]
        if (!DEEP) begin
          nxt_fifo_ctrl[5:4] = 2'b00; // [RL8]
        end
      end
      // clear bits are never stored; only the flush pulses carry them
      nxt_fifo_ctrl[`UFL_FC_RXCLR] = 1'b0;
      nxt_fifo_ctrl[`UFL_FC_TXCLR] = 1'b0;
    end
  end

  always @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      fifo_ctrl_ff <= `UFL_FC_RESET; // [RL1]
    end else begin
      fifo_ctrl_ff <= nxt_fifo_ctrl;
    end
  end

  // flush pulses: disable, mode change or explicit clear bits
  wire mode_change;
  wire fc_accept;
  assign mode_change = wr_fc && (wbyte[`UFL_FC_EN] != fifo_ctrl_ff[`UFL_FC_EN]); // [RL3]
  assign fc_accept = wr_fc && wbyte[`UFL_FC_EN];
  always @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      rx_fifo_flush_out <= 1'b0;
      tx_fifo_flush_out <= 1'b0;
    end else begin
      rx_fifo_flush_out <= mode_change || (wr_fc && !wbyte[`UFL_FC_EN]) ||
                           (fc_accept && wbyte[`UFL_FC_RXCLR]); // [RL5]
      tx_fifo_flush_out <= mode_change || (wr_fc && !wbyte[`UFL_FC_EN]) ||
                           (fc_accept && wbyte[`UFL_FC_TXCLR]); // [RL6]
    end
  end

  // ==========================================================================
  // occupancy counters; flush wins over any same-cycle push
  localparam CW = 7;
  reg [CW-1:0] rx_count_ff;
  reg [CW-1:0] tx_count_ff;
  always @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      rx_count_ff <= {CW{1'b0}};
      tx_count_ff <= {CW{1'b0}};
    end else begin
      if (rx_fifo_flush_out) begin
        rx_count_ff <= {CW{1'b0}}; // [RL5] [RL22]
      end else if (rx_push_in && !rx_pop_in && rx_count_ff != FIFO_DEPTH[CW-1:0]) begin
        rx_count_ff <= rx_count_ff + 7'd1;
      end else if (rx_pop_in && !rx_push_in && rx_count_ff != {CW{1'b0}}) begin
        rx_count_ff <= rx_count_ff - 7'd1;
      end
      if (tx_fifo_flush_out) begin
        tx_count_ff <= {CW{1'b0}}; // [RL6] [RL22]
      end else if (tx_push_in && !tx_pop_in && tx_count_ff != FIFO_DEPTH[CW-1:0]) begin
        tx_count_ff <= tx_count_ff + 7'd1;
      end else if (tx_pop_in && !tx_push_in && tx_count_ff != {CW{1'b0}}) begin
        tx_count_ff <= tx_count_ff - 7'd1;
      end
    end
  end

  // ==========================================================================
  // line control register and unlock
  reg [7:0] line_ctrl_ff;
  reg enh_ff;
  always @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      line_ctrl_ff <= `UFL_LC_RESET; // [RL18]
      enh_ff <= 1'b0;
    end else if (wr_lc) begin
      line_ctrl_ff <= wbyte;
      enh_ff <= DEEP && (wbyte == `UFL_LC_UNLOCK); // [RL17]
    end
  end

  // ==========================================================================
  // trigger table lookup
  reg [6:0] rx_trg;
  reg [6:0] tx_trg;
  always @* begin
    case (fifo_ctrl_ff[7:6]) // [RL9]
      2'b00: rx_trg = DEEP ? `UFL_RX64_0 : `UFL_RX16_0;
      2'b01: rx_trg = DEEP ? `UFL_RX64_1 : `UFL_RX16_1;
      2'b10: rx_trg = DEEP ? `UFL_RX64_2 : `UFL_RX16_2;
      default: rx_trg = DEEP ? `UFL_RX64_3 : `UFL_RX16_3;
    endcase
    case (fifo_ctrl_ff[5:4]) // [RL8]
      2'b00: tx_trg = `UFL_TX64_0;
      2'b01: tx_trg = `UFL_TX64_1;
      2'b10: tx_trg = `UFL_TX64_2;
      default: tx_trg = `UFL_TX64_3;
    endcase
    if (!DEEP) begin
      tx_trg = 7'd0;
    end
  end

  // ==========================================================================
  // registered decoded controls
  always @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      fifo_enable_out <= 1'b0;
      dma_mode_out <= 1'b0;
      rx_trigger_out <= 7'd0;
      tx_trigger_out <= 7'd0;
      data_bits_out <= 4'd5;
      two_stop_out <= 1'b0;
      half_stop_out <= 1'b0;
      parity_enable_out <= 1'b0;
      parity_even_out <= 1'b0;
      parity_stick_out <= 1'b0;
      parity_stick_value_out <= 1'b0;
      divisor_access_out <= 1'b0;
      enhanced_access_out <= 1'b0;
      rx_trigger_hit_out <= 1'b0;
      tx_below_trigger_out <= 1'b0;
    end else begin
      fifo_enable_out <= fifo_ctrl_ff[`UFL_FC_EN]; // [RL2]
      dma_mode_out <= fifo_ctrl_ff[`UFL_FC_EN] && fifo_ctrl_ff[`UFL_FC_DMA]; // [RL7]
      rx_trigger_out <= rx_trg;
      tx_trigger_out <= tx_trg;
      data_bits_out <= 4'd5 + {2'b00, line_ctrl_ff[1:0]}; // [RL10]
      two_stop_out <= line_ctrl_ff[`UFL_LC_STOP] && (line_ctrl_ff[1:0] != 2'b00); // [RL11]
      half_stop_out <= line_ctrl_ff[`UFL_LC_STOP] && (line_ctrl_ff[1:0] == 2'b00); // [RL11]
      parity_enable_out <= line_ctrl_ff[`UFL_LC_PEN]; // [RL12]
      parity_even_out <= line_ctrl_ff[`UFL_LC_EVEN]; // [RL12]
      parity_stick_out <= line_ctrl_ff[`UFL_LC_PEN] && line_ctrl_ff[`UFL_LC_STICK]; // [RL13]
      parity_stick_value_out <= !line_ctrl_ff[`UFL_LC_EVEN]; // [RL13]
      divisor_access_out <= line_ctrl_ff[`UFL_LC_DLAB]; // [RL16]
      enhanced_access_out <= enh_ff; // [RL17]
      rx_trigger_hit_out <= fifo_ctrl_ff[`UFL_FC_EN] && (rx_count_ff >= rx_trg);
      tx_below_trigger_out <= fifo_ctrl_ff[`UFL_FC_EN] && (tx_count_ff < tx_trg);
    end
  end

  // break forces space; shifter unaffected upstream
  assign serial_out = tx_shift_in && !line_ctrl_ff[`UFL_LC_BREAK]; // [RL14]

  // ==========================================================================
  // read channel
  assign s_axi_arready_out = !s_axi_rvalid_out;
  always @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= `UFL_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out <= `UFL_RESP_OKAY;
      if (s_axi_araddr_in[7:2] == `UFL_OFS_IDENT >> 2) begin
        // identification replaces fifo control on reads
        s_axi_rdata_out <= {24'h000000, `UFL_IDENT_IDLE |
                           (fifo_ctrl_ff[`UFL_FC_EN] ? `UFL_IDENT_FIFO_BITS : 8'h00)}; // [RL19] [RL20]
      end else if (s_axi_araddr_in[7:2] == `UFL_OFS_LINE_CTRL >> 2) begin
        s_axi_rdata_out <= {24'h000000, line_ctrl_ff};
      end else if (s_axi_araddr_in[7:2] == `UFL_OFS_STATUS >> 2) begin
        s_axi_rdata_out <= {28'h0000000, enh_ff, fifo_ctrl_ff[`UFL_FC_DMA],
                            fifo_ctrl_ff[`UFL_FC_EN], line_ctrl_ff[`UFL_LC_BREAK]};
      end else if (s_axi_araddr_in[7:2] == `UFL_OFS_FIFO_LVL >> 2) begin
        s_axi_rdata_out <= {9'h000, tx_count_ff, 9'h000, rx_count_ff};
      end else begin
        s_axi_rdata_out <= 32'h0000_0000;
        s_axi_rresp_out <= `UFL_RESP_SLVERR;
      end
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

endmodule // ufl_format_ctrl

// file: hw/ufl_map.vh
// register offsets, field positions, reset values and trigger tables for the format control block
`ifndef UFL_MAP_VH
`define UFL_MAP_VH
// register byte addresses
`define UFL_OFS_FIFO_CTRL 8'h08
`define UFL_OFS_LINE_CTRL 8'h0C
`define UFL_OFS_IDENT 8'h08
`define UFL_OFS_STATUS 8'h10
`define UFL_OFS_FIFO_LVL 8'h14
// fifo control fields
`define UFL_FC_EN 0
`define UFL_FC_RXCLR 1
`define UFL_FC_TXCLR 2
`define UFL_FC_DMA 3
`define UFL_FC_TXTRG_LO 4
`define UFL_FC_RXTRG_LO 6
`define UFL_FC_RESET 8'h00
// line control fields
`define UFL_LC_STOP 2
`define UFL_LC_PEN 3
`define UFL_LC_EVEN 4
`define UFL_LC_STICK 5
`define UFL_LC_BREAK 6
`define UFL_LC_DLAB 7
`define UFL_LC_RESET 8'h00
`define UFL_LC_UNLOCK 8'hBF
// identification value: no interrupt pending, fifo bits above
`define UFL_IDENT_IDLE 8'h01
`define UFL_IDENT_FIFO_BITS 8'hC0
// trigger tables, deep build then shallow build
`define UFL_TX64_0 7'd8
`define UFL_TX64_1 7'd16
`define UFL_TX64_2 7'd32
`define UFL_TX64_3 7'd56
`define UFL_RX64_0 7'd8
`define UFL_RX64_1 7'd16
`define UFL_RX64_2 7'd56
`define UFL_RX64_3 7'd60
`define UFL_RX16_0 7'd1
`define UFL_RX16_1 7'd4
`define UFL_RX16_2 7'd8
`define UFL_RX16_3 7'd14
`define UFL_DEEP 64
// axi responses
`define UFL_RESP_OKAY 2'b00
`define UFL_RESP_SLVERR 2'b10
`endif

// file: verification/ufl_format_ctrl_sva.sv
// assertion checker for the fifo and line format control block
`timescale 1ns/1ps
module ufl_format_ctrl_sva #(
  parameter FIFO_DEPTH = 64
) (
  // clock and reset
  input wire clk_sys_in,
  input wire rst_n_in,
  // watched ports
  input wire fifo_enable_out,
  input wire rx_fifo_flush_out,
  input wire tx_fifo_flush_out,
  input wire dma_mode_out,
  input wire [6:0] rx_trigger_out,
  input wire [3:0] data_bits_out,
  input wire two_stop_out,
  input wire half_stop_out,
  input wire parity_even_out,
  input wire parity_stick_out,
  input wire parity_stick_value_out,
  input wire divisor_access_out,
  input wire enhanced_access_out,
  input wire tx_shift_in,
  input wire serial_out
);
  reg [2:0] up_ff;
  // cycles since reset release, saturating at four
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) up_ff <= 3'h0;
    else if (up_ff != 3'h4) up_ff <= up_ff + 3'h1;
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // ==========
  // properties
  property p_break_low; serial_out |-> tx_shift_in; endproperty
  a_break_low: assert property (p_break_low)
    else $error("serial line high while shifter low");
  property p_dma_gate; dma_mode_out |-> fifo_enable_out; endproperty
  a_dma_gate: assert property (p_dma_gate)
    else $error("transfer mode set with fifos off");
  property p_mode_flush;
    $changed(fifo_enable_out) |-> (rx_fifo_flush_out && tx_fifo_flush_out) ||
      ($past(rx_fifo_flush_out) && $past(tx_fifo_flush_out));
  endproperty
  a_mode_flush: assert property (p_mode_flush)
    else $error("mode change without flush of both fifos");
  property p_flush_once;
    (rx_fifo_flush_out || tx_fifo_flush_out) |=> !rx_fifo_flush_out && !tx_fifo_flush_out;
  endproperty
  a_flush_once: assert property (p_flush_once)
    else $error("flush pulse longer than one cycle");
  property p_rx_trig;
    up_ff == 3'h4 |-> ((FIFO_DEPTH == 64) ? rx_trigger_out inside {7'h08, 7'h10, 7'h38, 7'h3C}
      : rx_trigger_out inside {7'h01, 7'h04, 7'h08, 7'h0E});
  endproperty
  a_rx_trig: assert property (p_rx_trig)
    else $error("receive trigger outside the table");
  property p_half_stop; half_stop_out |-> data_bits_out == 4'h5; endproperty
  a_half_stop: assert property (p_half_stop)
    else $error("half stop without five data bits");
  property p_stick; parity_stick_out |-> parity_stick_value_out == !parity_even_out; endproperty
  a_stick: assert property (p_stick)
    else $error("stick parity value not opposite of even select");
  property p_unlock;
    enhanced_access_out |-> FIFO_DEPTH == 64 && divisor_access_out && parity_stick_out &&
      two_stop_out && data_bits_out == 4'h8 && $past(serial_out) == $past(tx_shift_in);
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("enhanced access open without unlock value");
  c_unlock: cover property (enhanced_access_out);
  c_both_flush: cover property (rx_fifo_flush_out && tx_fifo_flush_out);
  c_half: cover property (half_stop_out);
endmodule // ufl_format_ctrl_sva

bind ufl_format_ctrl ufl_format_ctrl_sva #(.FIFO_DEPTH(FIFO_DEPTH)) sva_i (.clk_sys_in,
  .rst_n_in, .fifo_enable_out, .rx_fifo_flush_out, .tx_fifo_flush_out, .dma_mode_out,
  .rx_trigger_out, .data_bits_out, .two_stop_out, .half_stop_out, .parity_even_out,
  .parity_stick_out, .parity_stick_value_out, .divisor_access_out, .enhanced_access_out,
  .tx_shift_in, .serial_out);

// file: verification/ufl_datapath_model.sv
// data path partner: occupancy pulses and a running shifter level
`timescale 1ns/1ps
module ufl_datapath_model (
  // clock
  input wire clk_sys_in,
  // occupancy pulses and shifter level
  output reg [3:0] occ_pulse_out = 4'h0,
  output reg tx_shift_out = 1'b1
);
  // shifter keeps toggling so a forced break has something to mask
  always @(posedge clk_sys_in) begin
    tx_shift_out <= ~tx_shift_out;
  end
  // one-cycle pulse of {rx push, rx pop, tx push, tx pop}
  task pulse(input [3:0] sel);
    begin
      @(posedge clk_sys_in);
      occ_pulse_out <= sel;
      @(posedge clk_sys_in);
      occ_pulse_out <= 4'h0;
    end
  endtask
endmodule // ufl_datapath_model

// file: verification/ufl_format_ctrl_test.sv
// self-checking testbench for the fifo and line format control block
`timescale 1ns/1ps
module ufl_format_ctrl_test;
  reg clk_sys_in, rst_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
  reg s_axi_arvalid_in, s_axi_rready_in;
  reg [7:0] s_axi_awaddr_in, s_axi_araddr_in;
  reg [31:0] s_axi_wdata_in;
  reg [3:0] s_axi_wstrb_in;
  wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  wire s_axi_rvalid_out, fifo_enable_out, rx_fifo_flush_out, tx_fifo_flush_out, dma_mode_out;
  wire two_stop_out, half_stop_out, parity_enable_out, parity_even_out, parity_stick_out;
  wire parity_stick_value_out, divisor_access_out, enhanced_access_out, serial_out;
  wire rx_trigger_hit_out, tx_below_trigger_out, tx_shift_in;
  wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
  wire [31:0] s_axi_rdata_out;
  wire [6:0] rx_trigger_out, tx_trigger_out;
  wire [3:0] data_bits_out, occ;
  integer fails = 0, tests_run = 0, i;
  reg [31:0] rdv;
  reg [1:0] rsp;
  localparam [27:0] RXT = {7'h3C, 7'h38, 7'h10, 7'h08};
  localparam [27:0] TXT = {7'h38, 7'h20, 7'h10, 7'h08};
  ufl_format_ctrl #(.FIFO_DEPTH(64)) uut (.clk_sys_in, .rst_n_in, .s_axi_awaddr_in,
    .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
    .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
    .s_axi_rready_in, .rx_push_in(occ[3]), .rx_pop_in(occ[2]), .tx_push_in(occ[1]),
    .tx_pop_in(occ[0]), .tx_shift_in, .fifo_enable_out, .rx_fifo_flush_out, .tx_fifo_flush_out,
    .dma_mode_out, .rx_trigger_out, .tx_trigger_out, .data_bits_out, .two_stop_out,
    .half_stop_out, .parity_enable_out, .parity_even_out, .parity_stick_out,
    .parity_stick_value_out, .divisor_access_out, .enhanced_access_out, .serial_out,
    .rx_trigger_hit_out, .tx_below_trigger_out);
  ufl_datapath_model dp (.clk_sys_in, .occ_pulse_out(occ), .tx_shift_out(tx_shift_in));
  // ==========
  // shared tasks
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    reg ah, wh, bh;
    begin
      @(posedge clk_sys_in);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= {24'h000000, d};
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      s_axi_bready_in <= 1'b1;
      bh = 1'b0;
      // wait for the response; only the watchdog ends a hung wait
      while (!bh) begin
        @(negedge clk_sys_in);
        ah = s_axi_awvalid_in && s_axi_awready_out;
        wh = s_axi_wvalid_in && s_axi_wready_out;
        bh = s_axi_bvalid_out;
        if (bh) chk("bresp", 32'(s_axi_bresp_out), 32'h0);
        @(posedge clk_sys_in);
        if (ah) s_axi_awvalid_in <= 1'b0;
        if (wh) s_axi_wvalid_in <= 1'b0;
      end
      s_axi_bready_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
    end
  endtask
  task rd(input [7:0] a);
    reg ah, rh;
    begin
      @(posedge clk_sys_in);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      s_axi_rready_in <= 1'b1;
      rh = 1'b0;
      // wait for read data; only the watchdog ends a hung wait
      while (!rh) begin
        @(negedge clk_sys_in);
        ah = s_axi_arvalid_in && s_axi_arready_out;
        rh = s_axi_rvalid_out;
        rdv = s_axi_rdata_out;
        rsp = s_axi_rresp_out;
        @(posedge clk_sys_in);
        if (ah) s_axi_arvalid_in <= 1'b0;
      end
      s_axi_rready_in <= 1'b0;
      @(negedge clk_sys_in);
    end
  endtask
  // ==========
  // scenarios
  task t_reset;
    begin
      rd(8'h0C);
      chk("line reset", rdv, 32'h0);
      rd(8'h08);
      chk("ident off", rdv, 32'h1);
      chk("fifo_en", 32'(fifo_enable_out), 32'h0);
      chk("rx_trig", 32'(rx_trigger_out), 32'h8);
      chk("bits", 32'(data_bits_out), 32'h5);
      rd(8'h30);
      chk("unmapped", {rdv[29:0], rsp}, 32'h2);
    end
  endtask
  task t_codes;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        wr(8'h08, {i[1:0], i[1:0], 4'h9});
        chk("rx_trig", 32'(rx_trigger_out), 32'(RXT[i*7 +: 7]));
        chk("tx_trig", 32'(tx_trigger_out), 32'(TXT[i*7 +: 7]));
        chk("dma", 32'(dma_mode_out), 32'h1);
      end
      rd(8'h08);
      chk("ident on", rdv, 32'hC1);
      wr(8'h08, 8'h08);
      chk("fifo_en", 32'(fifo_enable_out), 32'h0);
      chk("kept trig", 32'(rx_trigger_out), 32'h3C);
      chk("dma off", 32'(dma_mode_out), 32'h0);
    end
  endtask
  task t_levels;
    begin
      wr(8'h08, 8'h01);
      repeat (9) dp.pulse(4'h8);
      dp.pulse(4'h4);
      repeat (3) dp.pulse(4'h2);
      dp.pulse(4'h1);
      repeat (2) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      chk("rx hit", 32'(rx_trigger_hit_out), 32'h1);
      rd(8'h14);
      chk("levels", rdv, 32'h00020008);
      wr(8'h08, 8'h03);
      rd(8'h14);
      chk("rx flush", rdv, 32'h00020000);
      wr(8'h08, 8'h05);
      rd(8'h14);
      chk("tx flush", rdv, 32'h0);
      chk("tx below", 32'(tx_below_trigger_out), 32'h1);
      repeat (2) dp.pulse(4'hA);
      wr(8'h08, 8'h00);
      rd(8'h14);
      chk("mode flush", rdv, 32'h0);
      // stale bytes pushed while off must not survive the enabling write
      repeat (2) dp.pulse(4'h8);
      wr(8'h08, 8'h03);
      rd(8'h14);
      chk("enable flush", rdv, 32'h0);
    end
  endtask
  task t_format;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        wr(8'h0C, {6'h01, i[1:0]});
        chk("bits", 32'(data_bits_out), 32'(i + 5));
        chk("half", 32'(half_stop_out), 32'(i == 0));
        if (i != 0) chk("two", 32'(two_stop_out), 32'h1);
        rd(8'h0C);
        chk("line rw", rdv, 32'(i + 4));
      end
      wr(8'h0C, 8'h38);
      chk("parity", {parity_enable_out, parity_even_out, parity_stick_value_out}, 32'h6);
      wr(8'h0C, 8'h28);
      chk("stick", {parity_stick_out, parity_even_out, parity_stick_value_out}, 32'h5);
      wr(8'h0C, 8'h40); // break only while no character is queued
      chk("break", {serial_out, tx_shift_in}, {1'b0, tx_shift_in});
      @(negedge clk_sys_in);
      chk("break", {serial_out, tx_shift_in}, {1'b0, tx_shift_in});
      rd(8'h10);
      chk("status", rdv, 32'h3);
      wr(8'h0C, 8'h80);
      chk("divisor", {divisor_access_out, serial_out}, {1'b1, tx_shift_in});
      wr(8'h0C, 8'hBF);
      chk("unlock", 32'(enhanced_access_out), 32'h1);
      wr(8'h0C, 8'h03);
      chk("relock", {enhanced_access_out, divisor_access_out}, 32'h0);
      // a write without the low byte lane leaves line control alone
      s_axi_wstrb_in <= 4'hE;
      wr(8'h0C, 8'h40);
      s_axi_wstrb_in <= 4'hF;
      rd(8'h0C);
      chk("no lane", {rdv[7:0], serial_out}, {8'h03, tx_shift_in});
    end
  endtask
  task complete_run;
    begin
      if (fails == 0 && tests_run > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // ==========
  // clock, watchdog and main sequence
  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    fails = fails + 1;
    complete_run;
  end
  initial begin
    {rst_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 4'h0;
    {s_axi_arvalid_in, s_axi_rready_in, s_axi_awaddr_in, s_axi_araddr_in} = 18'h0;
    s_axi_wdata_in = 32'h0;
    s_axi_wstrb_in = 4'hF;
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    t_reset;
    t_codes;
    t_levels;
    t_format;
    complete_run;
  end
endmodule // ufl_format_ctrl_test
